// ==== design/qpm_pkg.sv ====
// Functional notes
// - On the 64K variant, FFFF through FFFC are the mailboxes of ports one to four.
// - On the 32K variant, mailboxes are 7FFF through 7FFC, matched on bits 14:0.
// - A write by another port to a port's mailbox drives that port's interrupt low.
// - The flag is set on the writing port's rising clock edge.
// - A port writing its own mailbox stores data but raises no interrupt.
// - Each mailbox is an ordinary 18-bit word the target port can read back.
// - Simultaneous writes to one mailbox still set the flag; each byte lane takes the lowest-numbered writing port's data.
// - Setting depends on address, enables and direction; byte enables off keep the data.
// - An owner read clears the flag even with output or byte enables off.
// - A set flag stays low until the owner reads its own mailbox.
// - The flag is released on the reading port's rising clock edge.
// - Set needs a selected writer, clear a selected reader; deselected ports change no flag or mailbox, but their address counters still load.
// - Master reset acts asynchronously, with or without any port clock.
// - Master reset clears every port address counter to zero.
// - Master reset loads every counter mask register with all ones.
// - Master reset drives all mailbox and counter interrupts high and deselects registered controls.
// - A port is selected only with low-active enable low and high-active enable high.
package qpm_pkg;
  localparam int NPORT = 4;
  localparam int AW    = 16;
  localparam int DW    = 18;
  localparam int BW    = 9;

  localparam logic [15:0] MBOX_TOP_64K = 16'hFFFF;
  localparam logic [14:0] MBOX_TOP_32K = 15'h7FFF;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [15:0] MASK_RESET   = 16'hFFFF;

  localparam logic [5:0] OFS_STATUS = 6'h00;
  localparam logic [5:0] OFS_MASK   = 6'h04;
  localparam logic [5:0] OFS_CTRL   = 6'h08;
  localparam logic [5:0] OFS_FLAGS  = 6'h0C;
  localparam logic [5:0] OFS_MBOX   = 6'h10;
  localparam logic [5:0] OFS_CNT    = 6'h20;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  localparam int         CTRL_MBX_EN = 0;

  typedef struct packed {
    logic          clk;
    logic          chip_enable_low_active;
    logic          chip_enable_high_active;
    logic          rd_wr;
    logic          output_enable_n;
    logic          lower_byte_enable_n;
    logic          upper_byte_enable_n;
    logic [AW-1:0] port_address_bus;
    logic [DW-1:0] wdata;
  } qpm_port_s;

  // Deselected, read direction, outputs off
  localparam qpm_port_s PORT_IDLE = '{clk: 1'b0, chip_enable_low_active: 1'b1,
    chip_enable_high_active: 1'b0, rd_wr: 1'b1, output_enable_n: 1'b1,
    lower_byte_enable_n: 1'b1, upper_byte_enable_n: 1'b1,
    port_address_bus: 16'h0000, wdata: 18'h00000};
endpackage

// ==== design/qpm_mailbox_irq.sv ====
`timescale 1ns/10ps
`default_nettype none
module qpm_mailbox_irq #(
  parameter bit VARIANT_64K = 1'b1
) (
  input  wire logic                                      ref_clk,
  input  wire logic                                      rst,
  input  wire logic                                      master_reset_n,
  input  wire qpm_pkg::qpm_port_s [qpm_pkg::NPORT-1:0]   port_pins,
  output logic      [qpm_pkg::NPORT-1:0]                 mailbox_irq_n,
  output logic      [qpm_pkg::NPORT-1:0]                 counter_wrap_irq_n,
  output logic      [qpm_pkg::NPORT-1:0][qpm_pkg::DW-1:0] port_rdata,
  output logic      [qpm_pkg::NPORT-1:0]                 port_rdata_oe,
  input  wire logic [5:0]                                avs_address,
  input  wire logic                                      avs_read,
  input  wire logic                                      avs_write,
  input  wire logic [31:0]                               avs_writedata,
  output logic      [31:0]                               avs_readdata,
  output logic                                           avs_waitrequest,
  output logic                                           irq
);
  import qpm_pkg::*;

  // Master reset is asynchronous and needs no clock edge to act
  logic areset;
  assign areset = rst | ~master_reset_n;

  qpm_port_s [NPORT-1:0]        sync1;
  qpm_port_s [NPORT-1:0]        sync2;
  qpm_port_s [NPORT-1:0]        sync3;
  qpm_port_s [NPORT-1:0]        port_st;
  qpm_port_s [NPORT-1:0]        next_st;
  logic      [NPORT-1:0]        edge_p;
  logic      [NPORT-1:0]        sel;
  logic      [NPORT-1:0]        wr_acc;
  logic      [NPORT-1:0]        rd_acc;
  logic      [NPORT-1:0][NPORT-1:0] hit;
  logic      [NPORT-1:0]        set_req;
  logic      [NPORT-1:0]        clr_req;
  logic      [NPORT-1:0]        flag;
  logic      [NPORT-1:0][DW-1:0] mbox;
  logic      [NPORT-1:0][AW-1:0] cnt;
  logic      [NPORT-1:0][AW-1:0] cnt_mask;
  logic      [NPORT-1:0]        status;
  logic      [NPORT-1:0]        irq_mask;
  logic      [3:0]              ctrl;
  logic                         ack;
  logic                         mbx_en;

  assign mbx_en = ctrl[CTRL_MBX_EN];

  genvar gp;
  genvar gt;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      logic [$bits(qpm_port_s)-1:0] agree;
      assign agree = ~(sync2[gp] ^ sync3[gp]);
      assign next_st[gp] = (sync2[gp] & agree) | (port_st[gp] & ~agree);

      // Pins cross in three stages; a change counts once stages two and three agree
      always_ff @(posedge ref_clk or posedge areset) begin
        if (areset) begin
          sync1[gp]   <= PORT_IDLE;
          sync2[gp]   <= PORT_IDLE;
          sync3[gp]   <= PORT_IDLE;
          port_st[gp] <= PORT_IDLE;
        end else begin
          sync1[gp]   <= port_pins[gp];
          sync2[gp]   <= sync1[gp];
          sync3[gp]   <= sync2[gp];
          port_st[gp] <= next_st[gp];
        end
      end

      // Controls are taken as they stood before this port's rising edge
      assign edge_p[gp] = next_st[gp].clk & ~port_st[gp].clk;
      assign sel[gp] = ~port_st[gp].chip_enable_low_active
                       & port_st[gp].chip_enable_high_active;
      assign wr_acc[gp] = edge_p[gp] & sel[gp] & ~port_st[gp].rd_wr;
      assign rd_acc[gp] = edge_p[gp] & sel[gp] & port_st[gp].rd_wr;

      for (gt = 0; gt < NPORT; gt++) begin : g_hit
        if (VARIANT_64K) begin : g_64k
          assign hit[gp][gt] = port_st[gp].port_address_bus
                               == (MBOX_TOP_64K - 16'(gt));
        end else begin : g_32k
          assign hit[gp][gt] = port_st[gp].port_address_bus[14:0]
                               == (MBOX_TOP_32K - 15'(gt));
        end
      end

      // Address counter follows each load; wrap logic is not modelled here
      always_ff @(posedge ref_clk or posedge areset) begin
        if (areset) begin
          cnt[gp]                <= CNT_RESET;
          cnt_mask[gp]           <= MASK_RESET;
          counter_wrap_irq_n[gp] <= 1'b1;
        end else if (edge_p[gp]) begin
          cnt[gp] <= port_st[gp].port_address_bus & cnt_mask[gp];
        end
      end

      always_ff @(posedge ref_clk or posedge areset) begin
        if (areset) begin
          port_rdata[gp]    <= 18'h00000;
          port_rdata_oe[gp] <= 1'b0;
        end else if (edge_p[gp]) begin
          port_rdata[gp]    <= mbox[gp];
          // Bus stays off unless outputs and a byte lane are enabled
          port_rdata_oe[gp] <= rd_acc[gp] & hit[gp][gp] & ~port_st[gp].output_enable_n
                               & ~(port_st[gp].lower_byte_enable_n
                                   & port_st[gp].upper_byte_enable_n);
        end
      end
    end
  endgenerate

  always_comb begin
    for (int t = 0; t < NPORT; t++) begin
      set_req[t] = 1'b0;
      for (int p = 0; p < NPORT; p++) begin
        if (p != t) begin
          set_req[t] = set_req[t] | (wr_acc[p] & hit[p][t]);
        end
      end
      set_req[t] = set_req[t] & mbx_en;
      clr_req[t] = rd_acc[t] & hit[t][t] & mbx_en;
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge ref_clk or posedge areset) begin
    if (areset) begin
      flag <= 4'h0;
    end else begin
      flag <= set_req | (flag & ~clr_req);
    end
  end
  assign mailbox_irq_n = ~flag;

  // Mailbox words; per byte lane, lowest port wins a same-cycle collision
  always_ff @(posedge ref_clk or posedge areset) begin
    if (areset) begin
      mbox <= '0;
    end else begin
      for (int t = 0; t < NPORT; t++) begin
        for (int p = NPORT - 1; p >= 0; p--) begin
          if (wr_acc[p] && hit[p][t]) begin
            if (!port_st[p].lower_byte_enable_n) begin
              mbox[t][BW-1:0] <= port_st[p].wdata[BW-1:0];
            end
            if (!port_st[p].upper_byte_enable_n) begin
              mbox[t][DW-1:BW] <= port_st[p].wdata[DW-1:BW];
            end
          end
        end
      end
    end
  end

  // Avalon slave: one wait cycle, then the access completes
  logic        acc_req;
  logic        wr_take;
  logic [31:0] rd_mux;
  assign acc_req         = avs_read | avs_write;
  assign avs_waitrequest = acc_req & ~ack;
  assign wr_take         = avs_write & ack;

  always_ff @(posedge ref_clk or posedge areset) begin
    if (areset) begin
      ack <= 1'b0;
    end else begin
      ack <= acc_req & ~ack;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address)
      OFS_STATUS: rd_mux = {28'h0000000, status};
      OFS_MASK:   rd_mux = {28'h0000000, irq_mask};
      OFS_CTRL:   rd_mux = {28'h0000000, ctrl};
      OFS_FLAGS:  rd_mux = {28'h0000000, flag};
      default: begin
        for (int i = 0; i < NPORT; i++) begin
          if (avs_address == OFS_MBOX + 6'(4 * i)) begin
            rd_mux = {14'h0000, mbox[i]};
          end
          if (avs_address == OFS_CNT + 6'(4 * i)) begin
            rd_mux = {cnt_mask[i], cnt[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge areset) begin
    if (areset) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack) begin
      avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk or posedge areset) begin
    if (areset) begin
      ctrl     <= CTRL_RESET;
      irq_mask <= 4'h0;
    end else if (wr_take && avs_address == OFS_CTRL) begin
      ctrl <= avs_writedata[3:0];
    end else if (wr_take && avs_address == OFS_MASK) begin
      irq_mask <= avs_writedata[3:0];
    end
  end

  // Sticky mailbox-set events; write one clears, a new set wins
  always_ff @(posedge ref_clk or posedge areset) begin
    if (areset) begin
      status <= 4'h0;
    end else if (wr_take && avs_address == OFS_STATUS) begin
      status <= set_req | (status & ~avs_writedata[3:0]);
    end else begin
      status <= set_req | status;
    end
  end
  assign irq = |(status & irq_mask);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (areset);

  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_chk
      a_set_by_other: assert property (set_req[gp] |=> !mailbox_irq_n[gp])
        else $error("mailbox write by another port did not raise interrupt");
      a_clear_by_owner: assert property (clr_req[gp] && !set_req[gp] |=> mailbox_irq_n[gp])
        else $error("owner mailbox read did not release interrupt");
      a_low_holds: assert property (!mailbox_irq_n[gp] && !clr_req[gp] |=> !mailbox_irq_n[gp])
        else $error("interrupt released without owner read");
      a_rise_cause: assert property ($fell(mailbox_irq_n[gp]) |-> $past(set_req[gp]))
        else $error("interrupt fell without a foreign mailbox write");
      a_own_write_quiet: assert property (wr_acc[gp] && hit[gp][gp] && mailbox_irq_n[gp]
          && (wr_acc & ~(4'b0001 << gp)) == 4'h0 |=> mailbox_irq_n[gp])
        else $error("own mailbox write raised interrupt");
      a_deselect_idle: assert property (!sel[gp] |-> !wr_acc[gp] && !rd_acc[gp])
        else $error("deselected port made an access");
      a_set_beats_clear: assert property (set_req[gp] && clr_req[gp] |=> flag[gp])
        else $error("clear won over a same cycle set");
      a_data_no_lanes: assert property (wr_acc[gp] && hit[gp][(gp + 1) % NPORT]
          && port_st[gp].lower_byte_enable_n && port_st[gp].upper_byte_enable_n
          && (wr_acc & ~(4'b0001 << gp)) == 4'h0
          |=> $stable(mbox[(gp + 1) % NPORT]) && flag[(gp + 1) % NPORT])
        else $error("lane-less mailbox write changed data or missed flag");
      a_clear_no_bus: assert property (clr_req[gp] && port_st[gp].output_enable_n
          |=> !port_rdata_oe[gp] && !flag[gp] || $past(set_req[gp]))
        else $error("silent owner read drove bus or kept flag");
    end
  endgenerate

  a_stored_word: assert property (wr_acc == 4'b0010 && hit[1][0]
      && !port_st[1].lower_byte_enable_n && !port_st[1].upper_byte_enable_n
      |=> mbox[0] == $past(port_st[1].wdata))
    else $error("mailbox word not stored");
  a_reset_state: assert property (@(posedge ref_clk) disable iff (1'b0)
      $past(areset) |-> mailbox_irq_n == 4'hF && counter_wrap_irq_n == 4'hF
      && cnt == '0 && cnt_mask == {NPORT{MASK_RESET}})
    else $error("master reset state wrong");

  c_set_then_clear: cover property (set_req[0] ##[1:50] clr_req[0]);
  c_double_set: cover property ($countones(wr_acc & {hit[3][0], hit[2][0], hit[1][0], 1'b0}) > 1);
  c_irq_out: cover property ($rose(irq));
endmodule
`default_nettype wire

// ==== test/qpm_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module qpm_host_model
  import qpm_pkg::*;
(
  input  wire logic              ref_clk,
  output var  qpm_pkg::qpm_port_s pins
);
  initial pins = PORT_IDLE;

  // One access; the port clock gives a single rising edge and then stands still
  task automatic access(input logic [15:0] a, input logic rw, input logic [1:0] ce,
                        input logic [1:0] be_n, input logic oe_n, input logic [17:0] d);
    qpm_port_s p;
    p = PORT_IDLE;
    p.chip_enable_low_active  = ce[1];
    p.chip_enable_high_active = ce[0];
    p.rd_wr                   = rw;
    p.output_enable_n         = oe_n;
    p.lower_byte_enable_n     = be_n[0];
    p.upper_byte_enable_n     = be_n[1];
    p.port_address_bus        = a;
    p.wdata                   = d;
    pins <= p;
    repeat (6) @(posedge ref_clk);
    pins.clk <= 1'b1;
    repeat (6) @(posedge ref_clk);
    pins.clk <= 1'b0;
    repeat (6) @(posedge ref_clk);
    // Released address and data lines show the inverse of their last value, never a stale copy
    p                  = PORT_IDLE;
    p.port_address_bus = ~a;
    p.wdata            = ~d;
    pins <= p;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ==== test/quad_port_mailbox_irq_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module quad_port_mailbox_irq_bench;
  import qpm_pkg::*;
  logic                     ref_clk, rst, master_reset_n, avs_read, avs_write;
  wire qpm_port_s [NPORT-1:0] pins;
  logic [NPORT-1:0]         irq_n, irq32_n, cw_n, oe;
  logic [NPORT-1:0][DW-1:0] rdata;
  logic [5:0]               avs_address;
  logic                     avs_waitrequest, irq;
  logic [31:0]              avs_writedata, avs_readdata, rd;
  logic [3:0]               m_flag, m_stat;
  logic [DW-1:0]            m_word [NPORT];
  logic [17:0]              d1, d2;
  int                       err_total, num_checks, w;

  qpm_mailbox_irq #(.VARIANT_64K(1'b1)) uut (.ref_clk(ref_clk), .rst(rst),
    .master_reset_n(master_reset_n), .port_pins(pins), .mailbox_irq_n(irq_n),
    .counter_wrap_irq_n(cw_n), .port_rdata(rdata), .port_rdata_oe(oe),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  qpm_mailbox_irq #(.VARIANT_64K(1'b0)) uut_b (.ref_clk(ref_clk), .rst(rst),
    .master_reset_n(master_reset_n), .port_pins(pins), .mailbox_irq_n(irq32_n),
    .counter_wrap_irq_n(), .port_rdata(), .port_rdata_oe(), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(), .avs_waitrequest(), .irq());
  for (genvar g = 0; g < NPORT; g++) begin : h
    qpm_host_model hm (.ref_clk(ref_clk), .pins(pins[g]));
  end

  function automatic logic [15:0] mb(input int t);
    return 16'hFFFF - 16'(t);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    n = 0;
    // Waitrequest and read data are read as they stood at this rising edge
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest && n < 50);
    if (n >= 50) begin
      err_total++;
      report_and_stop();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Host access plus reference model update; ce is {low-active, high-active}
  task automatic op(input int p, input logic [15:0] a, input logic rw, input logic [1:0] ce,
                    input logic [1:0] be_n, input logic oe_n, input logic [17:0] d);
    logic sel;
    sel = (ce == 2'b01);
    case (p)
      0: h[0].hm.access(a, rw, ce, be_n, oe_n, d);
      1: h[1].hm.access(a, rw, ce, be_n, oe_n, d);
      2: h[2].hm.access(a, rw, ce, be_n, oe_n, d);
      default: h[3].hm.access(a, rw, ce, be_n, oe_n, d);
    endcase
    for (int t = 0; t < NPORT; t++) if (sel && a == mb(t)) begin
      if (!rw && p != t) {m_flag[t], m_stat[t]} = 2'b11;
      if (rw && p == t) m_flag[t] = 1'b0;
      if (!rw && !be_n[0]) m_word[t][8:0] = d[8:0];
      if (!rw && !be_n[1]) m_word[t][17:9] = d[17:9];
    end
    chk("mailbox_irq_n", irq_n, {28'h0000000, ~m_flag});
    if (sel && rw && a == mb(p)) chk("port_rdata", rdata[p], m_word[p]);
    chk("port_rdata_oe", oe[p], sel && rw && a == mb(p) && !oe_n && be_n != 2'b11);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    #300000;
    err_total++;
    report_and_stop();
  end

  initial begin
    {rst, master_reset_n, avs_read, avs_write} = 4'hC;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    {m_flag, m_stat, err_total, num_checks} = '0;
    void'($urandom(32'hae28e640));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("irq_n", irq_n, 32'h0000000F);
    chk("cnt_irq_n", cw_n, 32'h0000000F);
    for (int p = 0; p < NPORT; p++) begin
      av(1'b0, 6'(OFS_CNT + 4 * p), 32'h0, rd);
      chk("cnt", rd, {MASK_RESET, CNT_RESET});
    end
    av(1'b1, OFS_MASK, 32'hF, rd);
    for (int t = 0; t < NPORT; t++) begin
      w = (t + 1 + int'($urandom_range(2))) % NPORT;
      d1 = 18'($urandom);
      d2 = 18'($urandom);
      op(t, mb(t), 1'b0, 2'b01, 2'b00, 1'b1, d1);
      op(w, mb(t), 1'b0, 2'b01, 2'b01, 1'b1, d2);
      op(w, mb(t), 1'b1, 2'b01, 2'b00, 1'b0, 0);
      op(t, mb(t), 1'b1, 2'b01, 2'b00, 1'b1, 0);
      op(w, mb(t), 1'b0, 2'b01, 2'b11, 1'b1, d1);
      op(t, mb(t), 1'b1, 2'b00, 2'b00, 1'b0, 0);
      op(t, mb(t), 1'b1, 2'b01, 2'b10, 1'b0, 0);
      op(w, mb(t), 1'b0, 2'b11, 2'b00, 1'b1, d1);
    end
    av(1'b0, OFS_STATUS, 32'h0, rd);
    chk("status", rd, {28'h0000000, m_stat});
    chk("irq", irq, 32'h1);
    av(1'b1, OFS_MASK, 32'h0, rd);
    chk("irq masked", irq, 32'h0);
    av(1'b1, OFS_MASK, 32'hF, rd);
    av(1'b1, OFS_STATUS, 32'h5, rd);
    av(1'b0, OFS_STATUS, 32'h0, rd);
    chk("status w1c", rd, 32'hA);
    av(1'b1, OFS_STATUS, 32'hF, rd);
    chk("irq cleared", irq, 32'h0);
    av(1'b0, 6'h3C, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    fork
      h[1].hm.access(mb(0), 1'b0, 2'b01, 2'b00, 1'b1, 18'h00000);
      h[2].hm.access(mb(0), 1'b0, 2'b01, 2'b00, 1'b1, 18'h3FFFF);
    join
    chk("dual set", irq_n[0], 32'h0);
    // A lane-less foreign write in the owner's read cycle leaves the flag set
    m_word[0] = 18'h00000;
    fork
      h[0].hm.access(mb(0), 1'b1, 2'b01, 2'b00, 1'b1, 18'h00000);
      h[3].hm.access(mb(0), 1'b0, 2'b01, 2'b11, 1'b1, 18'h00000);
    join
    chk("set beats clear", irq_n[0], 32'h0);
    m_flag[0] = 1'b1;
    op(0, mb(0), 1'b1, 2'b01, 2'b11, 1'b1, 0);
    op(1, 16'h7FFF, 1'b0, 2'b01, 2'b11, 1'b1, 0);
    chk("irq_n 32k set", irq32_n[0], 32'h0);
    op(0, 16'h7FFF, 1'b1, 2'b01, 2'b11, 1'b1, 0);
    chk("irq_n 32k clear", irq32_n[0], 32'h1);
    op(2, mb(0), 1'b0, 2'b01, 2'b11, 1'b1, 0);
    master_reset_n <= 1'b0;
    #1;
    chk("irq_n master_reset_n", irq_n, 32'h0000000F);
    m_flag = 4'h0;
    @(posedge ref_clk);
    master_reset_n <= 1'b1;
    @(posedge ref_clk);
    av(1'b0, OFS_STATUS, 32'h0, rd);
    chk("status master_reset_n", rd, 32'h0);
    av(1'b0, OFS_CNT, 32'h0, rd);
    chk("cnt master_reset_n", rd, {MASK_RESET, CNT_RESET});
    report_and_stop();
  end
endmodule
`default_nettype wire
